// [core/ctp_timer16.v]
/*
 cascaded 16-bit timer / event counter / pwm generator, control as plain ports.
 assumes all inputs but count_input_pin synchronous to core_clk; fs_tick is a one-cycle pulse at
 the low-frequency rate; slow_mode is high in slow and sleep operation.
*/
// Summary of operation
// R1: timer mode counts the chained 16-bit counter on the chosen internal tick.
// R2: after start, a match raises the timer interrupt, clears, keeps counting.
// R3: software writes compare low byte, then high byte, never only one.
// R4: timer/event compare has no buffer; software must not change it while running.
// R5: software keeps the flip-flop init bit at 0 in timer and event modes.
// R6: timer clocks fc/2^11,2^7,2^5,2^3; select bit swaps slowest for fs/2^3.
// R7: event mode counts each falling edge on the count input pin.
// R8: event match raises the event interrupt, clears, resumes on later edges.
// R9: the count input holds each level at least two machine cycles.
// R10: pwm toggles flip-flop on compare match, again on overflow with interrupt.
// R11: the pwm flip-flop loads from its init bit and resets to 0.
// R12: the pwm pin always drives the inverse of the flip-flop.
// R13: pwm compare is buffered; loaded at interrupt when running, at once when stopped.
// R14: reading pwm compare during pwm output returns the buffered shift value.
// R15: software writes pwm compare low byte then high byte, never only one.
// R16: software updates pwm compare right after the interrupt, avoiding the transfer.
// R17: on stop the pin keeps its level; init bit changes only after the stop.
// R18: software stops the timer before entering stop mode.
// R19: pwm adds fs, fc/2 and fc; slow mode allows only fs/2^3 and fs.
// R20: software sets the shared port latch to 1 before pwm output.
// R21: count input is synchronised; interrupts are single-cycle pulses.
`timescale 1ns/100ps
`include "ctp_defs.vh"

module ctp_timer16 #(
   parameter CNT_W = 16
) (
   input  wire             core_clk,
   input  wire             sys_rst,
   input  wire             fs_tick,
   input  wire             slow_mode,
   input  wire [1:0]       mode_sel,
   input  wire [2:0]       clk_sel,
   input  wire             divider_select_bit,
   input  wire             run_bit,
   input  wire             flipflop_init_bit,
   input  wire             compare_low_byte_we,
   input  wire             compare_high_byte_we,
   input  wire             pwm_compare_low_byte_we,
   input  wire             pwm_compare_high_byte_we,
   input  wire [7:0]       wr_data,
   input  wire             count_input_pin,
   output reg  [CNT_W-1:0] compare_rd,
   output reg  [CNT_W-1:0] pwm_compare_rd,
   output reg  [CNT_W-1:0] count_rd,
   output reg              output_flipflop,
   output wire             pwm_out_pin,
   output reg              timer_match_irq,
   output reg              event_match_irq,
   output wire             timer_irq_any
);
   wire [`CTP_PRE_W-1:0] fc_tick;
   wire                  fs_div8_tick;

   reg  [CNT_W-1:0] cnt_q;
   reg  [CNT_W-1:0] cmp_q;
   reg  [CNT_W-1:0] pwm_buf_q;
   reg  [CNT_W-1:0] pwm_act_q;
   reg  [7:0]       pwm_low_hold_q;
   reg              pwm_pend_q;
   reg              run_q;
   reg              init_q;
   reg              cin_s1_q;
   reg              cin_s2_q;
   reg              cin_s3_q;
   reg              tick;

   ctp_prescaler #(
      .W            (`CTP_PRE_W)
   ) u_pre (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .fs_tick      (fs_tick),
      .fc_tick      (fc_tick),
      .fs_div8_tick (fs_div8_tick)
   );

   wire mode_timer = (mode_sel == `CTP_MODE_TIMER);
   wire mode_event = (mode_sel == `CTP_MODE_EVENT);
   wire mode_pwm   = (mode_sel == `CTP_MODE_PWM);

   // source tick select; fc-derived options are dead while running slow
   always @* begin
      tick = 1'b0;
      case (clk_sel)
         `CTP_SRC_DIV11: tick = (divider_select_bit | slow_mode) ? fs_div8_tick
                                 : fc_tick[`CTP_TAP_DIV11];              // R6
         `CTP_SRC_DIV7:  tick = ~slow_mode & fc_tick[`CTP_TAP_DIV7];      // R6
         `CTP_SRC_DIV5:  tick = ~slow_mode & fc_tick[`CTP_TAP_DIV5];      // R6
         `CTP_SRC_DIV3:  tick = ~slow_mode & fc_tick[`CTP_TAP_DIV3];      // R6
         `CTP_SRC_FS:    tick = mode_pwm & fs_tick;                       // R19
         `CTP_SRC_FC_DIV2: tick = mode_pwm & ~slow_mode & fc_tick[`CTP_TAP_DIV1]; // R19
         `CTP_SRC_FC:    tick = mode_pwm & ~slow_mode;                    // R19
         default:        tick = 1'b0;
      endcase
   end

   // the second and third stages feed the edge detector
   wire cin_fall = cin_s3_q & ~cin_s2_q;                                  // R21
   wire step     = mode_event ? cin_fall : tick;                          // R7
   wire running  = run_q & ~(mode_sel == `CTP_MODE_OFF);
   wire hit_cmp  = running & step & (cnt_q == cmp_q) & ~mode_pwm;
   wire pwm_ovf  = running & step & mode_pwm & (&cnt_q);
   wire pwm_hit  = running & step & mode_pwm & (cnt_q == pwm_act_q);
   wire init_chg = init_q ^ flipflop_init_bit;
   wire pwm_wr   = pwm_compare_high_byte_we;
   wire [CNT_W-1:0] pwm_wr_val = {wr_data, pwm_low_hold_q};

   always @(posedge core_clk) begin
      if (sys_rst) begin
         cin_s1_q <= 1'b1;
         cin_s2_q <= 1'b1;
         cin_s3_q <= 1'b1;
      end else begin
         cin_s1_q <= count_input_pin;                                     // R21
         cin_s2_q <= cin_s1_q;                                            // R21
         cin_s3_q <= cin_s2_q;
      end
   end

   // counter and match logic
   always @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_q           <= `CTP_CNT_RST;
         run_q           <= 1'b0;
         timer_match_irq <= 1'b0;
         event_match_irq <= 1'b0;
      end else begin
         run_q           <= run_bit;
         timer_match_irq <= 1'b0;
         event_match_irq <= 1'b0;
         if (!running) begin
            // counter clears while stopped so each start counts from zero
            cnt_q <= `CTP_CNT_RST;
         end else if (hit_cmp) begin
            cnt_q <= `CTP_CNT_RST;                                        // R2 R8
            if (mode_event)
               event_match_irq <= 1'b1;                                   // R8 R21
            else
               timer_match_irq <= 1'b1;                                   // R2 R21
         end else if (pwm_ovf) begin
            cnt_q           <= `CTP_CNT_RST;                              // R10
            timer_match_irq <= 1'b1;                                      // R10 R21
         end else if (step) begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};                   // R1 R7
         end
      end
   end

   // compare registers; timer compare has no buffer stage
   always @(posedge core_clk) begin
      if (sys_rst) begin
         cmp_q          <= {CNT_W{1'b1}};
         pwm_buf_q      <= {CNT_W{1'b0}};
         pwm_act_q      <= {CNT_W{1'b0}};
         pwm_low_hold_q <= 8'h00;
         pwm_pend_q     <= 1'b0;
      end else begin
         if (compare_low_byte_we)
            cmp_q[7:0] <= wr_data;                                        // R4
         if (compare_high_byte_we)
            cmp_q[CNT_W-1:8] <= wr_data;                                  // R4
         // low byte is held until the high byte, so both land together
         if (pwm_compare_low_byte_we)
            pwm_low_hold_q <= wr_data;
         if (pwm_wr)
            pwm_buf_q <= pwm_wr_val;                                      // R13
         if (!running && (pwm_wr || pwm_pend_q)) begin
            pwm_act_q  <= pwm_wr ? pwm_wr_val : pwm_buf_q;                // R13
            pwm_pend_q <= 1'b0;
         end else if (pwm_ovf) begin
            // a write in the transfer cycle wins, see the write-timing caveat
            pwm_act_q  <= pwm_wr ? pwm_wr_val : pwm_buf_q;                // R13
            pwm_pend_q <= 1'b0;
         end else if (pwm_wr) begin
            pwm_pend_q <= 1'b1;
         end
      end
   end

   // output flip-flop: toggles while running in pwm mode, holds on stop
   always @(posedge core_clk) begin
      if (sys_rst) begin
         output_flipflop <= `CTP_FF_RST;                                  // R11
         init_q          <= 1'b0;
      end else begin
         init_q <= flipflop_init_bit;
         if (pwm_ovf)
            output_flipflop <= ~output_flipflop;                          // R10
         else if (pwm_hit)
            output_flipflop <= ~output_flipflop;                          // R10
         else if (!running && !run_bit && init_chg)
            output_flipflop <= flipflop_init_bit;                         // R11 R17
         else if (!running && run_bit)
            output_flipflop <= flipflop_init_bit;                         // R11
      end
   end

   assign pwm_out_pin   = ~output_flipflop;                               // R12
   assign timer_irq_any = timer_match_irq | event_match_irq;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         compare_rd     <= {CNT_W{1'b0}};
         pwm_compare_rd <= {CNT_W{1'b0}};
         count_rd       <= {CNT_W{1'b0}};
      end else begin
         compare_rd     <= cmp_q;
         pwm_compare_rd <= (mode_pwm & running) ? pwm_act_q : pwm_buf_q;  // R14
         count_rd       <= cnt_q;
      end
   end
endmodule // ctp_timer16

// [core/ctp_defs.vh]
/*
 header of constants for the cascaded 16-bit timer / pwm unit.
 assumes it is included by bare name from the design files under core/.
*/
`ifndef CTP_DEFS_VH
`define CTP_DEFS_VH

// operating modes on mode_sel
`define CTP_MODE_TIMER   2'h0
`define CTP_MODE_EVENT   2'h1
`define CTP_MODE_PWM     2'h2
`define CTP_MODE_OFF     2'h3

// source clock select codes on clk_sel
`define CTP_SRC_DIV11    3'h0
`define CTP_SRC_DIV7     3'h1
`define CTP_SRC_DIV5     3'h2
`define CTP_SRC_DIV3     3'h3
`define CTP_SRC_FS       3'h4
`define CTP_SRC_FC_DIV2  3'h5
`define CTP_SRC_FC       3'h6

// prescaler tap positions (divide by 2^(n+1) uses bit n)
`define CTP_TAP_DIV11    10
`define CTP_TAP_DIV7     6
`define CTP_TAP_DIV5     4
`define CTP_TAP_DIV3     2
`define CTP_TAP_DIV1     0

// prescaler width, reset values
`define CTP_PRE_W        11
`define CTP_CNT_RST      16'h0000
`define CTP_FF_RST       1'b0

`endif

// [core/ctp_prescaler.v]
/*
 free-running prescaler giving one-cycle enable pulses at fc/2^n and fs/2^3.
 assumes core_clk is fc and fs_tick is a one-cycle pulse at the fs rate.
*/
`timescale 1ns/100ps
`include "ctp_defs.vh"

module ctp_prescaler #(
   parameter W = `CTP_PRE_W
) (
   input  wire         core_clk,
   input  wire         sys_rst,
   input  wire         fs_tick,
   output wire [W-1:0] fc_tick,
   output wire         fs_div8_tick
);
   reg  [W-1:0] pre_q;
   reg  [2:0]   fs_pre_q;
   wire [W:0]   carry;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         pre_q    <= {W{1'b0}};
         fs_pre_q <= 3'h0;
      end else begin
         pre_q <= pre_q + {{(W-1){1'b0}}, 1'b1};
         if (fs_tick)
            fs_pre_q <= fs_pre_q + 3'h1;
      end
   end

   // tick n fires once per 2^(n+1) clocks, on the wrap of bits n..0
   assign carry[0] = 1'b1;
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_tap
         assign carry[i+1]  = carry[i] & pre_q[i];
         assign fc_tick[i]  = carry[i+1];
      end
   endgenerate

   assign fs_div8_tick = fs_tick & (fs_pre_q == 3'h7);
endmodule // ctp_prescaler

// [tb/ctp_props.sv]
/*
 concurrent checks on the ports of ctp_timer16.
 assumes one clock core_clk and a synchronous active-high sys_rst.
*/
`timescale 1ns/100ps

module ctp_props #(
   parameter CNT_W = 16
) (
   input wire             core_clk,
   input wire             sys_rst,
   input wire             run_bit,
   input wire             flipflop_init_bit,
   input wire [CNT_W-1:0] count_rd,
   input wire             output_flipflop,
   input wire             pwm_out_pin,
   input wire             timer_match_irq,
   input wire             event_match_irq,
   input wire             timer_irq_any
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_pin_inv; pwm_out_pin == !output_flipflop; endproperty
   a_pin_inv: assert property (p_pin_inv) else $error("pwm pin not inverted");
   property p_ff_rst; disable iff (1'b0) sys_rst |=> !output_flipflop; endproperty
   a_ff_rst: assert property (p_ff_rst) else $error("flip-flop not cleared");
   property p_irq_any; timer_irq_any == (timer_match_irq || event_match_irq); endproperty
   a_irq_any: assert property (p_irq_any) else $error("combined irq wrong");
   property p_tpulse; timer_match_irq |=> !timer_match_irq; endproperty
   a_tpulse: assert property (p_tpulse) else $error("timer irq too long");
   property p_epulse; event_match_irq |=> !event_match_irq; endproperty
   a_epulse: assert property (p_epulse) else $error("event irq too long");
   // two stopped samples mean no step can be in flight
   property p_quiet; !run_bit ##1 !run_bit |=> !timer_irq_any; endproperty
   a_quiet: assert property (p_quiet) else $error("irq while stopped");
   property p_clr_stop; !run_bit [*5] |-> count_rd == '0; endproperty
   a_clr_stop: assert property (p_clr_stop) else $error("counter not clear");
   property p_ff_hold;
      (!run_bit && $stable(flipflop_init_bit)) [*4] |-> $stable(output_flipflop);
   endproperty
   a_ff_hold: assert property (p_ff_hold) else $error("flip-flop moved stopped");
endmodule // ctp_props

bind ctp_timer16 ctp_props #(.CNT_W(CNT_W)) i_ctp_props (.core_clk(core_clk),
   .sys_rst(sys_rst), .run_bit(run_bit), .flipflop_init_bit(flipflop_init_bit),
   .count_rd(count_rd), .output_flipflop(output_flipflop), .pwm_out_pin(pwm_out_pin),
   .timer_match_irq(timer_match_irq), .event_match_irq(event_match_irq),
   .timer_irq_any(timer_irq_any));

// [tb/ctp_far_side.sv]
/*
 external pulse source on the count input pin.
 assumes req is a level from the bench; the pin idles high as with a pull-up.
*/
`timescale 1ns/100ps

module ctp_far_side #(
   parameter HOLD = 3
) (
   input  wire core_clk,
   input  wire req,
   output reg  count_input_pin
);
   integer t = 0;
   initial count_input_pin = 1'b1;
   // each level held HOLD cycles; HOLD must not drop below two
   always @(posedge core_clk) begin
      t = (t + 1) % HOLD;
      if (t == 0) count_input_pin <= #1 req ? ~count_input_pin : 1'b1;
   end
endmodule // ctp_far_side

// [tb/ctp_timer16_tb_top.sv]
/*
 bench for ctp_timer16: timer, event and pwm runs driven through byte writes.
 assumes core/ is on the include path.
*/
`timescale 1ns/100ps
`include "ctp_defs.vh"

module ctp_timer16_tb_top;
   reg         core_clk = 1'b0;
   reg         sys_rst  = 1'b1;
   reg         fs_tick  = 1'b0;
   reg  [1:0]  fs_cnt   = 2'h0;
   reg  [1:0]  mode_sel = `CTP_MODE_OFF;
   reg  [2:0]  clk_sel  = 3'h0;
   reg         dsb      = 1'b0;
   reg         run_bit  = 1'b0;
   reg         ffi      = 1'b0;
   reg  [3:0]  we       = 4'h0;
   reg  [7:0]  wr_data  = 8'h00;
   reg         req      = 1'b0;
   wire        pin, ff, pout, tirq, eirq;
   wire [15:0] cmp_rd, pcmp_rd, cnt_rd;
   integer     errors = 0, check_count = 0, n, k, ecnt = 0, e0;

   always #5 core_clk = ~core_clk;
   // fs far faster than real so the fs/8 case stays short
   always @(posedge core_clk) begin
      fs_cnt  <= #1 fs_cnt + 2'h1;
      fs_tick <= #1 (fs_cnt == 2'h3);
      // an unknown irq before reset settles must not poison the tally
      ecnt    <= ecnt + (eirq === 1'b1);
   end
   ctp_far_side i_ctp_far_side (.core_clk(core_clk), .req(req), .count_input_pin(pin));
   ctp_timer16 i_ctp_timer16 (.core_clk(core_clk), .sys_rst(sys_rst), .fs_tick(fs_tick),
      .slow_mode(1'b0), .mode_sel(mode_sel), .clk_sel(clk_sel), .divider_select_bit(dsb),
      .run_bit(run_bit), .flipflop_init_bit(ffi), .compare_low_byte_we(we[0]),
      .compare_high_byte_we(we[1]), .pwm_compare_low_byte_we(we[2]),
      .pwm_compare_high_byte_we(we[3]), .wr_data(wr_data), .count_input_pin(pin),
      .compare_rd(cmp_rd), .pwm_compare_rd(pcmp_rd), .count_rd(cnt_rd),
      .output_flipflop(ff), .pwm_out_pin(pout), .timer_match_irq(tirq),
      .event_match_irq(eirq), .timer_irq_any());

   task chk(input [8*12-1:0] what, input [15:0] exp, input [15:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value %0s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task cyc(input integer c);
      begin
         repeat (c) @(posedge core_clk);
         #1;
      end
   endtask
   // low byte then high byte, back to back
   task wr16(input integer i, input [15:0] v);
      begin
         cyc(1);
         we[i] = 1'b1;
         wr_data = v[7:0];
         cyc(1);
         we[i] = 1'b0;
         we[i+1] = 1'b1;
         wr_data = v[15:8];
         cyc(1);
         we = 4'h0;
      end
   endtask
   task wirq(input integer lim);
      begin
         n = 0;
         while (tirq !== 1'b1 && n < lim) begin
            cyc(1);
            n = n + 1;
         end
         if (n >= lim)
            errors = errors + 1;
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d errors %0d", check_count, errors);
         if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   initial begin
      #900000;
      errors = errors + 1;
      complete_run;
   end
   initial begin
      cyc(8);
      sys_rst = 1'b0;
      cyc(1);
      chk("pin", 16'h1, pout);
      chk("flipflop", 16'h0, ff);
      chk("compare", 16'hffff, cmp_rd);
      mode_sel = `CTP_MODE_TIMER;
      wr16(0, 16'h0001);
      cyc(1);
      chk("compare", 16'h0001, cmp_rd);
      for (k = 1; k < 5; k = k + 1) begin
         run_bit = 1'b0;
         clk_sel = {1'b0, k[1:0]};
         dsb = (k == 4);
         cyc(6);
         run_bit = 1'b1;
         wirq(600);
         cyc(1);
         wirq(600);
         chk("period", 2 * ((k == 4) ? 32 : (1 << (9 - 2 * k))), n + 1);
      end
      run_bit = 1'b0;
      mode_sel = `CTP_MODE_EVENT;
      wr16(0, 16'h0003);
      run_bit = 1'b1;
      cyc(4);
      e0 = ecnt;
      req = 1'b1;
      repeat (8) @(negedge pin);
      req = 1'b0;
      cyc(12);
      chk("event irqs", 2, ecnt - e0);
      run_bit = 1'b0;
      mode_sel = `CTP_MODE_PWM;
      clk_sel = `CTP_SRC_FC;
      wr16(2, 16'h0010);
      cyc(2);
      chk("pwm compare", 16'h0010, pcmp_rd);
      ffi = 1'b1;
      cyc(3);
      chk("pin", 16'h0, pout);
      run_bit = 1'b1;
      n = 0;
      while (ff !== 1'b0 && n < 40) begin
         cyc(1);
         n = n + 1;
      end
      if (n >= 40)
         errors = errors + 1;
      chk("pin", 16'h1, pout);
      wr16(2, 16'h0020);
      cyc(1);
      chk("pwm compare", 16'h0010, pcmp_rd);
      wirq(70000);
      cyc(2);
      chk("flipflop", 16'h1, ff);
      chk("pwm compare", 16'h0020, pcmp_rd);
      run_bit = 1'b0;
      cyc(4);
      chk("flipflop", 16'h1, ff);
      ffi = 1'b0;
      cyc(3);
      chk("pin", 16'h1, pout);
      complete_run;
   end
endmodule // ctp_timer16_tb_top
